/* File: dsp_host.sv */
// host model: i2c master and spi master on the shared pads
// assumes: the bench resolves pad levels and feeds them back here
`timescale 1ns/1ps
module dsp_host (
    output logic h_scl,
    output logic h_cs_n,
    output logic h_sda,
    output logic h_en,
    input wire logic scl_w,
    input wire logic sda_w,
    input wire logic sdo_w
);
    localparam realtime Q = 625ns;
    localparam realtime H = 62.5ns;
    int stalls = 0;
    logic [7:0] wd [8];
    logic [7:0] rd [8];
    initial begin
        h_scl = 1'b1;
        h_cs_n = 1'b1;
        h_sda = 1'b1;
        h_en = 1'b0;
    end
    // slave may hold scl low; bounded so a stuck stretch still ends
    task automatic pulse(output logic s);
        int n;
        n = 0;
        #Q h_scl = 1'b1;
        while (scl_w !== 1'b1 && n < 5000) begin
            #10;
            n++;
        end
        if (n == 5000) stalls++;
        #Q s = sda_w;
        #Q h_scl = 1'b0;
        #Q;
    endtask : pulse
    // also serves as repeated start
    task automatic start();
        h_en = 1'b0;
        #Q h_scl = 1'b1;
        #Q h_en = 1'b1;
        h_sda = 1'b0;
        #Q h_scl = 1'b0;
        #Q;
    endtask : start
    task automatic stop();
        h_en = 1'b1;
        h_sda = 1'b0;
        #Q h_scl = 1'b1;
        #Q h_en = 1'b0;
        #Q;
    endtask : stop
    // msb first, data released for the ack clock
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            h_en = 1'b1;
            h_sda = b[i];
            pulse(s);
        end
        h_en = 1'b0;
        pulse(s);
        ack = ~s;
    endtask : wbyte
    // ack bytes still wanted, none after the last
    task automatic rbyte(input logic master_acknowledge, output logic [7:0] b);
        logic s;
        h_en = 1'b0;
        for (int i = 7; i >= 0; i--) pulse(b[i]);
        h_en = master_acknowledge;
        h_sda = 1'b0;
        pulse(s);
        h_en = 1'b0;
    endtask : rbyte
    // cs low per frame, spc parked high outside
    // change on falling spc, sample on rising
    task automatic spi(input logic r, input logic [6:0] idx, input int nb,
                       input logic tw);
        logic [7:0] hdr;
        hdr = {r, idx};
        #7 h_cs_n = 1'b0;
        h_en = 1'b1;
        for (int b = 0; b < nb; b++) begin
            #H h_scl = 1'b0;
            if (b < 8) h_sda = hdr[7 - b];
            else begin
                h_sda = wd[b / 8 - 1][7 - b % 8];
                h_en = ~(r & tw);
            end
            #H h_scl = 1'b1;
            if (b >= 8) rd[b / 8 - 1][7 - b % 8] = tw ? sda_w : sdo_w;
        end
        #H h_cs_n = 1'b1;
        h_en = 1'b0;
    endtask : spi
endmodule : dsp_host

/* File: dsp_map.svh */
// constant map for the dual serial register port
// assumes: included by bare name from the port module and the bench
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH

// upper six bits of the 7-bit slave address, low bit comes from a pad
`define DSP_ADDR_HI 6'h2e
// direction bit value meaning the master reads
`define DSP_DIR_READ 1'b1
// bits in one transferred byte
`define DSP_BYTE_BITS 4'h8
// position of the last bit of an spi byte block
`define DSP_SPI_LAST 3'h7
// register index step for auto-increment
`define DSP_IDX_STEP 7'h01
// synchroniser reset: scl, sda and chip select idle high
`define DSP_SYNC_RST 6'h07

`endif

/* File: dsp_pkg.sv */
// types shared by the dual serial register port
// assumes: nothing beyond the constant map
package dsp_pkg;

    typedef enum logic [2:0] {
        I_IDLE,
        I_RX,
        I_ACK,
        I_LOAD,
        I_TX,
        I_MACK
    } dsp_i2c_state_t;

    typedef enum logic [1:0] {
        K_ADDR,
        K_SUB,
        K_DATA
    } dsp_kind_t;

    // one register access towards the register file
    typedef struct packed {
        logic [6:0] index;
        logic [7:0] data;
    } dsp_access_t;

endpackage : dsp_pkg

/* File: dsp_serial_port.sv */
// i2c and spi slave front end sharing one set of pads
// assumes: register file outside; core_clk 50 MHz; spc_clk is the
// serial clock pad, also sampled as the i2c clock in the core domain
`timescale 1ns/1ps
`include "dsp_map.svh"

module dsp_serial_port (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic spc_clk,
    input wire logic cs_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic sdo_in,
    output logic sdo_out,
    output logic sdo_oe_n,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic auto_inc,
    input wire logic three_wire_select,
    output dsp_pkg::dsp_access_t reg_access,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ready,
    output logic [6:0] spi_rd_index,
    input wire logic [7:0] spi_rd_byte
);

    function automatic logic [6:0] next_index(input logic [6:0] idx,
                                              input logic inc);
        return inc ? idx + `DSP_IDX_STEP : idx;
    endfunction : next_index

    // flops read here before the process that drives them
    dsp_pkg::dsp_access_t acc_q;
    logic reg_wr_q;
    logic reg_rd_q;
    dsp_pkg::dsp_access_t spi_acc_q;
    logic spi_tog_q;
    logic spi_rd_ph_q;

    // core-domain synchronisers: scl, sda, cs_n, address pad,
    // spi write toggle, spi read phase
    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic tog_seen_q;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_q <= `DSP_SYNC_RST;
            sync_q <= `DSP_SYNC_RST;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (clk_en) begin
            // 50 MHz sampling leaves margin at 400 kHz scl
            meta_q <= {spi_rd_ph_q, spi_tog_q, sdo_in, cs_n, sda_in,
                       spc_clk};
            sync_q <= meta_q;
            scl_prev_q <= sync_q[0];
            sda_prev_q <= sync_q[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic i2c_on;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    assign scl_s = sync_q[0];
    assign sda_s = sync_q[1];
    assign i2c_on = sync_q[2];
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    dsp_pkg::dsp_i2c_state_t state_q;
    dsp_pkg::dsp_kind_t kind_q;
    logic [3:0] bits_q;
    logic [7:0] shreg_q;
    logic [7:0] txsh_q;
    logic rw_q;
    logic ack_q;
    logic drv_q;
    logic [6:0] idx_q;

    logic byte_done;
    logic go_load;
    logic load_take;
    assign byte_done = state_q == dsp_pkg::I_RX && scl_fall
                       && bits_q == `DSP_BYTE_BITS;
    assign go_load = scl_fall
        && ((state_q == dsp_pkg::I_ACK && kind_q == dsp_pkg::K_ADDR
             && rw_q == `DSP_DIR_READ)
            || (state_q == dsp_pkg::I_MACK && ack_q));
    assign load_take = state_q == dsp_pkg::I_LOAD && !reg_rd_q
                       && reg_ready;

    // i2c slave sequencer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= dsp_pkg::I_IDLE;
            kind_q <= dsp_pkg::K_ADDR;
            bits_q <= 4'h0;
            shreg_q <= 8'h00;
            txsh_q <= 8'h00;
            rw_q <= 1'b0;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
            idx_q <= 7'h00;
        end else if (clk_en) begin
            if (!i2c_on || stop_cond) begin
                state_q <= dsp_pkg::I_IDLE;
                drv_q <= 1'b0;
            end else if (start_cond) begin
                // start and repeated start both restart addressing
                state_q <= dsp_pkg::I_RX;
                kind_q <= dsp_pkg::K_ADDR;
                bits_q <= 4'h0;
                drv_q <= 1'b0;
            end else begin
                unique case (state_q)
                    dsp_pkg::I_IDLE: begin
                        drv_q <= 1'b0;
                    end
                    dsp_pkg::I_RX: begin
                        if (scl_rise) begin
                            shreg_q <= {shreg_q[6:0], sda_s};
                            bits_q <= bits_q + 4'h1;
                        end
                        if (byte_done) begin
                            unique case (kind_q)
                                dsp_pkg::K_ADDR: begin
                                    if (shreg_q[7:1] ==
                                        {`DSP_ADDR_HI, sync_q[3]}) begin
                                        rw_q <= shreg_q[0];
                                        state_q <= dsp_pkg::I_ACK;
                                        drv_q <= 1'b1;
                                    end else begin
                                        // line stays released
                                        state_q <= dsp_pkg::I_IDLE;
                                    end
                                end
                                dsp_pkg::K_SUB: begin
                                    // msb carries no index meaning
                                    idx_q <= shreg_q[6:0];
                                    state_q <= dsp_pkg::I_ACK;
                                    drv_q <= 1'b1;
                                end
                                default: begin
                                    idx_q <= next_index(idx_q, auto_inc);
                                    state_q <= dsp_pkg::I_ACK;
                                    drv_q <= 1'b1;
                                end
                            endcase
                        end
                    end
                    dsp_pkg::I_ACK: begin
                        // ack held from fall to next fall
                        if (scl_fall) begin
                            drv_q <= 1'b0;
                            bits_q <= 4'h0;
                            if (go_load) begin
                                state_q <= dsp_pkg::I_LOAD;
                            end else begin
                                state_q <= dsp_pkg::I_RX;
                                kind_q <= (kind_q == dsp_pkg::K_ADDR)
                                          ? dsp_pkg::K_SUB : dsp_pkg::K_DATA;
                            end
                        end
                    end
                    dsp_pkg::I_LOAD: begin
                        // scl held low until the byte is here
                        if (load_take) begin
                            drv_q <= ~reg_rdata[7];
                            txsh_q <= {reg_rdata[6:0], 1'b0};
                            bits_q <= 4'h1;
                            state_q <= dsp_pkg::I_TX;
                        end
                    end
                    dsp_pkg::I_TX: begin
                        if (scl_fall) begin
                            if (bits_q == `DSP_BYTE_BITS) begin
                                drv_q <= 1'b0;
                                state_q <= dsp_pkg::I_MACK;
                            end else begin
                                drv_q <= ~txsh_q[7];
                                txsh_q <= {txsh_q[6:0], 1'b0};
                                bits_q <= bits_q + 4'h1;
                            end
                        end
                    end
                    dsp_pkg::I_MACK: begin
                        if (scl_rise) begin
                            // a nack ends the burst until the next start
                            ack_q <= ~sda_s;
                            if (!sda_s) begin
                                idx_q <= next_index(idx_q, auto_inc);
                            end
                        end
                        if (scl_fall) begin
                            state_q <= go_load ? dsp_pkg::I_LOAD
                                               : dsp_pkg::I_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // register accesses from both slaves; only one is ever active
    always_ff @(posedge core_clk) begin
        if (srst) begin
            acc_q <= '0;
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
            tog_seen_q <= 1'b0;
        end else if (clk_en) begin
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
            tog_seen_q <= sync_q[4];
            if (sync_q[4] != tog_seen_q) begin
                // spi byte is held stable for a whole block
                acc_q <= spi_acc_q;
                reg_wr_q <= 1'b1;
            end else if (byte_done && kind_q == dsp_pkg::K_DATA) begin
                acc_q <= '{index: idx_q, data: shreg_q};
                reg_wr_q <= 1'b1;
            end else if (go_load) begin
                acc_q.index <= idx_q;
                reg_rd_q <= 1'b1;
            end
        end
    end

    // pad enables; low means the pad is driven
    logic sda_oe_n_q;
    logic sdo_oe_n_q;
    logic scl_oe_n_q;
    logic spi_read_on;
    assign spi_read_on = sync_q[5] & ~sync_q[2];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sda_oe_n_q <= 1'b1;
            sdo_oe_n_q <= 1'b1;
            scl_oe_n_q <= 1'b1;
        end else if (clk_en) begin
            sda_oe_n_q <= ~(drv_q | (spi_read_on & three_wire_select));
            sdo_oe_n_q <= ~(spi_read_on & ~three_wire_select);
            scl_oe_n_q <= ~(state_q == dsp_pkg::I_LOAD);
        end
    end

    // spi side, clocked by the serial clock; chip select high clears
    // the frame, so a partial byte never reaches a register
    logic [2:0] spc_cnt_q;
    logic data_ph_q;
    logic spi_rw_q;
    logic [6:0] spi_idx_q;
    logic [7:0] insh_q;
    logic auto_meta_q;
    logic auto_s_q;

    always_ff @(posedge spc_clk) begin
        auto_meta_q <= auto_inc;
        auto_s_q <= auto_meta_q;
    end

    always_ff @(posedge spc_clk or posedge cs_n) begin
        if (cs_n) begin
            spc_cnt_q <= 3'h0;
            data_ph_q <= 1'b0;
            spi_rw_q <= 1'b0;
            spi_idx_q <= 7'h00;
            insh_q <= 8'h00;
            spi_rd_ph_q <= 1'b0;
        end else begin
            insh_q <= {insh_q[6:0], sda_in};
            spc_cnt_q <= spc_cnt_q + 3'h1;
            if (!data_ph_q) begin
                if (spc_cnt_q == 3'h0) begin
                    spi_rw_q <= sda_in;
                end else begin
                    spi_idx_q <= {spi_idx_q[5:0], sda_in};
                end
                if (spc_cnt_q == `DSP_SPI_LAST) begin
                    data_ph_q <= 1'b1;
                    spi_rd_ph_q <= spi_rw_q;
                end
            end else if (spc_cnt_q == `DSP_SPI_LAST) begin
                spi_idx_q <= next_index(spi_idx_q, auto_s_q);
            end
        end
    end

    // write hand-off: toggle plus held word, cleared only by core reset

    always_ff @(posedge spc_clk or posedge srst) begin
        if (srst) begin
            spi_acc_q <= '0;
            spi_tog_q <= 1'b0;
        end else if (!cs_n && data_ph_q && !spi_rw_q
                     && spc_cnt_q == `DSP_SPI_LAST) begin
            spi_acc_q <= '{index: spi_idx_q,
                           data: {insh_q[6:0], sda_in}};
            spi_tog_q <= ~spi_tog_q;
        end
    end

    // read data leaves on falling edges, msb first from bit 8
    logic [7:0] outsh_q;
    logic spi_bit_q;

    always_ff @(negedge spc_clk or posedge cs_n) begin
        if (cs_n) begin
            outsh_q <= 8'h00;
            spi_bit_q <= 1'b0;
        end else if (data_ph_q && spi_rw_q && spc_cnt_q == 3'h0) begin
            spi_bit_q <= spi_rd_byte[7];
            outsh_q <= {spi_rd_byte[6:0], 1'b0};
        end else if (data_ph_q) begin
            spi_bit_q <= outsh_q[7];
            outsh_q <= {outsh_q[6:0], 1'b0};
        end
    end

    assign sda_out = spi_bit_q;
    assign sdo_out = spi_bit_q;
    assign scl_out = 1'b0;
    assign sda_oe_n = sda_oe_n_q;
    assign sdo_oe_n = sdo_oe_n_q;
    assign scl_oe_n = scl_oe_n_q;
    assign reg_access = acc_q;
    assign reg_wr = reg_wr_q;
    assign reg_rd = reg_rd_q;
    assign spi_rd_index = spi_idx_q;

    sequence s_addr_full;
        state_q == dsp_pkg::I_RX && kind_q == dsp_pkg::K_ADDR && byte_done;
    endsequence

    sequence s_ack_driven;
        state_q == dsp_pkg::I_ACK ##1 !sda_oe_n_q;
    endsequence

    chk_cs_idle: assert property (
        @(posedge core_clk) disable iff (srst || !clk_en)
        !i2c_on |=> state_q == dsp_pkg::I_IDLE)
        else $error("i2c active while chip select low");

    chk_addr_ack: assert property (
        @(posedge core_clk) disable iff (srst || !clk_en)
        s_addr_full ##0 (shreg_q[7:1] == {`DSP_ADDR_HI, sync_q[3]})
        |=> s_ack_driven)
        else $error("matching address not acknowledged");

    chk_addr_miss: assert property (
        @(posedge core_clk) disable iff (srst || !clk_en)
        s_addr_full ##0 (shreg_q[7:1] != {`DSP_ADDR_HI, sync_q[3]})
        |=> state_q == dsp_pkg::I_IDLE ##1 sda_oe_n_q)
        else $error("foreign address acknowledged");

    chk_ack_hold: assert property (
        @(posedge core_clk) disable iff (srst || !clk_en)
        state_q == dsp_pkg::I_ACK && scl_s && $past(scl_s) |-> !sda_oe_n_q)
        else $error("ack released during clock high");

    chk_sub_index: assert property (
        @(posedge core_clk) disable iff (srst || !clk_en)
        kind_q == dsp_pkg::K_SUB && byte_done
        |=> idx_q == $past(shreg_q[6:0]))
        else $error("sub-address not loaded as index");

    chk_i2c_inc: assert property (
        @(posedge core_clk) disable iff (srst || !clk_en)
        state_q == dsp_pkg::I_MACK && scl_rise && !sda_s && auto_inc
        |=> idx_q == $past(idx_q) + `DSP_IDX_STEP)
        else $error("index not advanced after master ack");

    chk_stretch: assert property (
        @(posedge core_clk) disable iff (srst || !clk_en)
        state_q == dsp_pkg::I_LOAD && !reg_ready |=> !scl_oe_n_q)
        else $error("clock not stretched while waiting");

    chk_tx_msb: assert property (
        @(posedge core_clk) disable iff (srst || !clk_en)
        load_take |=> state_q == dsp_pkg::I_TX
        ##1 sda_oe_n_q == $past(reg_rdata[7], 2))
        else $error("first read bit is not the msb");

    chk_spi_msb: assert property (
        @(negedge spc_clk) disable iff (cs_n)
        data_ph_q && spi_rw_q && spc_cnt_q == 3'h0
        |=> spi_bit_q == $past(spi_rd_byte[7]))
        else $error("spi read does not start with msb");

    chk_spi_write: assert property (
        @(posedge spc_clk) disable iff (srst || cs_n)
        data_ph_q && !spi_rw_q && spc_cnt_q == `DSP_SPI_LAST
        |=> spi_tog_q != $past(spi_tog_q))
        else $error("complete spi byte not handed over");

endmodule : dsp_serial_port

/* File: tb_dual_serial_register_port.sv */
// self-checking bench for the dual serial register port
// assumes: dsp_host drives the pads; the bench holds the register file
`timescale 1ns/1ps
`include "dsp_map.svh"
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("wrong value at %0t: got %h want %h", $time, g, e); \
    end \
end
module tb_dual_serial_register_port;
    typedef struct packed {
        logic [1:0] mode; // 0 i2c, 1 spi 4-wire, 2 spi 3-wire
        logic rd;
        logic inc;
        logic [6:0] idx;
        logic [3:0] n;
    } dsp_row_t;
    dsp_row_t rows [10] = '{
        '{2'h0, 1'h0, 1'h1, 7'h10, 4'h2}, '{2'h0, 1'h1, 1'h1, 7'h0f, 4'h3},
        '{2'h0, 1'h0, 1'h0, 7'h20, 4'h2}, '{2'h0, 1'h1, 1'h0, 7'h7f, 4'h2},
        '{2'h1, 1'h0, 1'h1, 7'h30, 4'h2}, '{2'h1, 1'h1, 1'h1, 7'h2e, 4'h3},
        '{2'h2, 1'h1, 1'h1, 7'h30, 4'h2}, '{2'h1, 1'h0, 1'h0, 7'h40, 4'h3},
        '{2'h2, 1'h0, 1'h1, 7'h50, 4'h1}, '{2'h1, 1'h1, 1'h0, 7'h05, 4'h2}};
    logic core_clk = 1'h0;
    logic srst = 1'h1;
    logic clk_en = 1'h1;
    logic auto_inc = 1'h1;
    logic three_wire_select = 1'h0;
    logic addr_sel = 1'h1;
    logic reg_ready = 1'h0;
    logic h_scl, h_cs_n, h_sda, h_en;
    logic sda_out, sda_oe_n, sdo_out, sdo_oe_n, scl_out, scl_oe_n;
    logic reg_wr, reg_rd, a;
    logic [6:0] spi_rd_index;
    logic [7:0] regs [128];
    logic [7:0] exp_q [8];
    dsp_pkg::dsp_access_t reg_access;
    dsp_row_t r;
    int failures = 0;
    int comparisons = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    int w0;
    int r0;
    // open-drain lines with pull-ups; device wins when it drives
    wire spc_w = h_scl & scl_oe_n;
    wire sda_w = !sda_oe_n ? sda_out : (h_en ? h_sda : 1'h1);
    wire sdo_w = !sdo_oe_n ? sdo_out : addr_sel;
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        reg_ready <= ~reg_rd; // read data valid one cycle late
        if (reg_rd) rd_cnt <= rd_cnt + 1;
        if (reg_wr) begin
            regs[reg_access.index] <= reg_access.data;
            wr_cnt <= wr_cnt + 1;
        end
    end
    dsp_serial_port u_dsp_serial_port (.core_clk(core_clk), .srst(srst),
        .clk_en(clk_en), .spc_clk(spc_w), .cs_n(h_cs_n), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sdo_in(sdo_w),
        .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .scl_out(scl_out),
        .scl_oe_n(scl_oe_n), .auto_inc(auto_inc),
        .three_wire_select(three_wire_select), .reg_access(reg_access),
        .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(regs[reg_access.index]), .reg_ready(reg_ready),
        .spi_rd_index(spi_rd_index), .spi_rd_byte(regs[spi_rd_index]));
    dsp_host u_dsp_host (.h_scl(h_scl), .h_cs_n(h_cs_n), .h_sda(h_sda),
        .h_en(h_en), .scl_w(spc_w), .sda_w(sda_w), .sdo_w(sdo_w));
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic i2c_run(input dsp_row_t t);
        logic [7:0] slave_address;
        slave_address = {`DSP_ADDR_HI, addr_sel, 1'h0};
        u_dsp_host.start();
        u_dsp_host.wbyte(slave_address, a);
        `CHK(a, 1'h1)
        u_dsp_host.wbyte({1'h1, t.idx}, a); // msb set; the slave ignores it
        `CHK(a, 1'h1)
        if (t.rd) begin
            u_dsp_host.start();
            u_dsp_host.wbyte(slave_address | 8'h01, a);
            `CHK(a, 1'h1)
            for (int k = 0; k < t.n; k++)
                u_dsp_host.rbyte(k < t.n - 1, u_dsp_host.rd[k]);
        end else begin
            for (int k = 0; k < t.n; k++) begin
                u_dsp_host.wbyte(u_dsp_host.wd[k], a);
                `CHK(a, 1'h1)
            end
        end
        u_dsp_host.stop();
    endtask : i2c_run
    task automatic reset_dut();
        @(posedge core_clk);
        srst <= 1'h1;
        repeat (5) @(posedge core_clk);
        srst <= 1'h0;
        @(posedge core_clk);
        #1;
        `CHK({sda_oe_n, sdo_oe_n, scl_oe_n, reg_wr}, 4'he)
    endtask : reset_dut
    initial begin
        repeat (100000) @(posedge core_clk);
        failures++;
        conclude();
    end
    initial begin
        for (int i = 0; i < 128; i++) regs[i] = 8'(i * 7 + 3);
        reset_dut();
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge core_clk);
            auto_inc <= r.inc;
            three_wire_select <= r.mode[1];
            for (int k = 0; k < 8; k++) begin
                u_dsp_host.wd[k] = 8'(r.idx + 8'h3c + 8'(k * 5));
                exp_q[k] = regs[7'(r.idx + (r.inc ? k : 0))];
            end
            w0 = wr_cnt;
            r0 = rd_cnt;
            repeat (4) @(posedge core_clk);
            if (r.mode == 2'h0) i2c_run(r);
            else u_dsp_host.spi(r.rd, r.idx, 8 + 8 * r.n, r.mode[1]);
            repeat (10) @(posedge core_clk);
            for (int k = 0; k < r.n; k++)
                if (r.rd) `CHK(u_dsp_host.rd[k], exp_q[k])
                else if (r.inc || k == r.n - 1) `CHK(regs[7'(r.idx + (r.inc ? k : 0))], u_dsp_host.wd[k])
            `CHK(wr_cnt - w0, r.rd ? 0 : int'(r.n))
            `CHK(rd_cnt - r0, (r.rd && r.mode == 2'h0) ? int'(r.n) : 0)
        end
        reset_dut();
        // foreign address stays unacknowledged, then the other pad level
        u_dsp_host.start();
        u_dsp_host.wbyte({`DSP_ADDR_HI, 1'h0, 1'h0}, a);
        `CHK(a, 1'h0)
        u_dsp_host.stop();
        @(posedge core_clk);
        addr_sel <= 1'h0;
        repeat (4) @(posedge core_clk);
        u_dsp_host.start();
        u_dsp_host.wbyte({`DSP_ADDR_HI, 1'h0, 1'h0}, a);
        `CHK(a, 1'h1)
        u_dsp_host.stop();
        // frame cut after four data bits writes nothing
        @(posedge core_clk);
        auto_inc <= 1'h1;
        three_wire_select <= 1'h0;
        w0 = wr_cnt;
        u_dsp_host.wd[0] = 8'h96;
        u_dsp_host.spi(1'h0, 7'h60, 12, 1'h0);
        repeat (10) @(posedge core_clk);
        `CHK(wr_cnt - w0, 0)
        u_dsp_host.spi(1'h0, 7'h60, 16, 1'h0);
        repeat (10) @(posedge core_clk);
        `CHK(regs[7'h60], 8'h96)
        // core frozen by clk_en: the spi byte waits in the hand-off
        @(posedge core_clk);
        clk_en <= 1'h0;
        w0 = wr_cnt;
        u_dsp_host.wd[0] = 8'h5a;
        u_dsp_host.spi(1'h0, 7'h61, 16, 1'h0);
        repeat (10) @(posedge core_clk);
        `CHK(wr_cnt - w0, 0)
        clk_en <= 1'h1;
        repeat (10) @(posedge core_clk);
        `CHK(regs[7'h61], 8'h5a)
        `CHK(u_dsp_host.stalls, 0)
        conclude();
    end
endmodule : tb_dual_serial_register_port
